// ===== hdl/rpsmc_pkg.sv
// Package of register map, field positions, reset values and timing figures
// Assumes a 100 MHz core clock and a 16-bit serial frame: flag, 7 address bits, 8 data bits
package rpsmc_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [6:0] ADDR_CFG    = 7'h00;
  localparam logic [6:0] ADDR_MUX    = 7'h01;
  localparam logic [6:0] ADDR_SCAN   = 7'h02;
  localparam logic [6:0] ADDR_RX_THRESHOLD_TX_LEVEL   = 7'h03;
  localparam logic [6:0] ADDR_PING   = 7'h04;
  localparam logic [6:0] ADDR_DWELL  = 7'h05;
  localparam logic [6:0] ADDR_RESULT = 7'h06;
  localparam logic [6:0] ADDR_STATUS = 7'h07;
  localparam int unsigned NUM_REGS   = 8;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RST_CFG   = 8'h84;
  localparam logic [2:0] RST_MUX   = 3'h0;
  localparam logic [3:0] RST_SCAN  = 4'h5;
  localparam logic [7:0] RST_RX_THRESHOLD_TX_LEVEL  = 8'hB7;
  localparam logic [7:0] RST_PING  = 8'h0F;
  localparam logic [7:0] RST_DWELL = 8'h00;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int unsigned CFG_XTAL   = 7;
  localparam int unsigned CFG_POWER_DOWN_BIT  = 6;
  localparam int unsigned CFG_STBY   = 5;
  localparam int unsigned CFG_TXON   = 4;
  localparam int unsigned CFG_OSCBUF = 2;
  localparam int unsigned CFG_RATE   = 0;
  localparam int unsigned SCAN_CHK   = 7;
  localparam int unsigned SCAN_FULL  = 6;
  localparam int unsigned SCAN_DW    = 4;
  localparam int unsigned SCAN_INDEX = 1;
  localparam int unsigned SCAN_START = 0;
  localparam int unsigned RX_THRESHOLD_TX_LEVEL_SENS  = 4;
  localparam int unsigned RX_THRESHOLD_TX_LEVEL_PWR   = 0;
  localparam int unsigned PING_HI    = 4;
  localparam int unsigned PING_MASK  = 0;

  // ************************************************************
  // Dwell codes and frame layout
  // ************************************************************
  localparam logic [1:0]  DWELL_MANUAL  = 2'h0;
  localparam logic [1:0]  DWELL_ONE     = 2'h1;
  localparam logic [1:0]  DWELL_SIXTEEN = 2'h2;
  localparam logic [1:0]  DWELL_USER    = 2'h3;
  localparam logic [12:0] MULT_SIXTEEN  = 13'h0010;
  localparam logic [12:0] MULT_ONE      = 13'h0001;
  localparam logic [4:0]  FRAME_BITS    = 5'h10;
  localparam logic [4:0]  ADDR_LAST     = 5'h07;
  localparam logic [4:0]  DATA_FIRST    = 5'h08;
  localparam logic [3:0]  DATA_TOP      = 4'hF;
  localparam logic [1:0]  SETTLE_CYC    = 2'h2;

  // ************************************************************
  // Bit periods
  // ************************************************************
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned BIT_NS_9K6  = 104160;
  localparam int unsigned BIT_NS_38K4 = 26040;
  localparam int unsigned BIT_NS_115K = 8680;
  localparam int unsigned BIT_CYC_9K6  = (BIT_NS_9K6 * CLK_MHZ) / 1000;
  localparam int unsigned BIT_CYC_38K4 = (BIT_NS_38K4 * CLK_MHZ) / 1000;
  localparam int unsigned BIT_CYC_115K = (BIT_NS_115K * CLK_MHZ) / 1000;

  typedef enum logic {SCAN_IDLE, SCAN_DWELL} rpsmc_scan_e;

endpackage

// ===== hdl/rpsmc_top.sv
// Mode control, serial register port and port scan engine of the modem
// Assumes analog receive and direction inputs are asynchronous; serial clock idles between frames
`timescale 1ns/1ps

module rpsmc_top #(
  parameter int unsigned P_BIT_CYC_9K6  = rpsmc_pkg::BIT_CYC_9K6,
  parameter int unsigned P_BIT_CYC_38K4 = rpsmc_pkg::BIT_CYC_38K4,
  parameter int unsigned P_BIT_CYC_115K = rpsmc_pkg::BIT_CYC_115K
) (
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  input  wire logic       i_spi_clk,
  input  wire logic       i_serial_select_n,
  input  wire logic       i_serial_in,
  output logic            o_serial_out,
  output logic            o_serial_out_oe_n,
  input  wire logic       i_transmit_input_pin,
  input  wire logic       i_rx_data_raw,
  input  wire logic       i_direction_raw,
  output logic            o_receive_output,
  output logic            o_direction,
  output logic            o_tx_enable,
  output logic            o_tx_key,
  output logic            o_rx_enable,
  output logic            o_osc_enable,
  output logic            o_sync_clock_output_enable,
  output logic [1:0]      o_sync_drive,
  output logic [3:0]      o_tx_level,
  output logic [3:0]      o_receive_threshold_field,
  output logic [1:0]      o_data_rate_field,
  output logic [1:0]      o_mux_port,
  output logic            o_mux_open
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [4:0]  sp_cnt_q;
  logic [14:0] sp_shift_q;
  logic        sp_rw_q;
  logic [7:0]  sp_rd_q;
  logic        sp_sdo_q;
  logic [6:0]  wr_addr_h_q;
  logic [7:0]  wr_data_h_q;
  logic        wr_tgl_q;
  logic [1:0]  cs_sync_q;
  logic [2:0]  tgl_sync_q;
  logic [1:0]  transmit_input_pin_sync_q;
  logic [1:0]  rxd_sync_q;
  logic [1:0]  dir_sync_q;
  logic [7:0]  snap_q [rpsmc_pkg::NUM_REGS];
  logic [7:0]  cfg_q;
  logic [2:0]  mux_q;
  logic [3:0]  scan_q;
  logic [7:0]  rx_threshold_tx_level_q;
  logic [7:0]  ping_q;
  logic [7:0]  dwell_q;
  logic [3:0]  detect_q;
  logic        tx_active_q;
  rpsmc_pkg::rpsmc_scan_e state_q;
  logic [1:0]  blank_q;
  logic        det_ok;
  logic [13:0] bit_tmr_q;
  logic [12:0] bit_num_q;
  logic        wr_evt;
  logic        start_pulse;
  logic        index_pulse;
  logic        scanning;
  logic        power_down_bit;
  logic        det;
  logic        manual;
  logic        expire;
  logic        advance;
  logic [2:0]  first_port;
  logic [2:0]  next_port;
  logic [13:0] period;
  logic [12:0] target;
  logic [7:0]  rd_val [rpsmc_pkg::NUM_REGS];

  // First unmasked port at or above start; bit 2 marks success
  function automatic logic [2:0] find_port(input logic [3:0] mask, input logic [2:0] start);
    logic [2:0] res;
    res = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      if (mask[i] && (3'(i) >= start)) begin
        res = {1'b1, 2'(i)};
      end
    end
    return res;
  endfunction

  // ************************************************************
  // Serial port, link clock domain
  // ************************************************************
  always_ff @(posedge i_spi_clk or posedge i_serial_select_n) begin
    if (i_serial_select_n) begin
      sp_cnt_q   <= 5'h00;
      sp_shift_q <= 15'h0000;
      sp_rw_q    <= 1'b0;
      sp_rd_q    <= 8'h00;
    end else if (sp_cnt_q != rpsmc_pkg::FRAME_BITS) begin
      sp_cnt_q   <= sp_cnt_q + 5'h01;
      sp_shift_q <= {sp_shift_q[13:0], i_serial_in};
      if (sp_cnt_q == 5'h00) begin
        sp_rw_q <= i_serial_in;
      end
      if (sp_cnt_q == rpsmc_pkg::ADDR_LAST) begin
        // Snapshot is frozen while the frame is open
        sp_rd_q <= ({sp_shift_q[5:0], i_serial_in} < 7'(rpsmc_pkg::NUM_REGS)) ?
                   snap_q[3'({sp_shift_q[1:0], i_serial_in})] : 8'h00;
      end
    end
  end

  always_ff @(posedge i_spi_clk or posedge i_serial_select_n) begin
    if (i_serial_select_n) begin
      wr_addr_h_q <= 7'h00;
      wr_data_h_q <= 8'h00;
    end else if (sp_cnt_q == (rpsmc_pkg::FRAME_BITS - 5'h01) && !sp_rw_q) begin
      wr_addr_h_q <= sp_shift_q[13:7];
      wr_data_h_q <= {sp_shift_q[6:0], i_serial_in};
    end
  end

  // Toggle survives frame end; only core reset clears it
  always_ff @(posedge i_spi_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_tgl_q <= 1'b0;
    end else if (!i_serial_select_n && sp_cnt_q == (rpsmc_pkg::FRAME_BITS - 5'h01)
                 && !sp_rw_q) begin
      wr_tgl_q <= ~wr_tgl_q;
    end
  end

  always_ff @(negedge i_spi_clk or posedge i_serial_select_n) begin
    if (i_serial_select_n) begin
      sp_sdo_q <= 1'b0;
    end else if (sp_rw_q && sp_cnt_q >= rpsmc_pkg::DATA_FIRST
                 && sp_cnt_q < rpsmc_pkg::FRAME_BITS) begin
      sp_sdo_q <= sp_rd_q[3'(rpsmc_pkg::DATA_TOP - sp_cnt_q[3:0])];
    end
  end

  assign o_serial_out      = sp_sdo_q;
  assign o_serial_out_oe_n = i_serial_select_n;

  // ************************************************************
  // Synchronisers into the core clock
  // ************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      cs_sync_q   <= 2'h0;
      tgl_sync_q  <= 3'h0;
      transmit_input_pin_sync_q <= 2'h3;
      rxd_sync_q  <= 2'h3;
      dir_sync_q  <= 2'h0;
    end else begin
      cs_sync_q   <= {cs_sync_q[0], ~i_serial_select_n};
      tgl_sync_q  <= {tgl_sync_q[1:0], wr_tgl_q};
      transmit_input_pin_sync_q <= {transmit_input_pin_sync_q[0], i_transmit_input_pin};
      rxd_sync_q  <= {rxd_sync_q[0], i_rx_data_raw};
      dir_sync_q  <= {dir_sync_q[0], i_direction_raw};
    end
  end

  assign wr_evt      = tgl_sync_q[2] ^ tgl_sync_q[1];
  assign start_pulse = wr_evt && wr_addr_h_q == rpsmc_pkg::ADDR_SCAN
                       && wr_data_h_q[rpsmc_pkg::SCAN_START];
  assign index_pulse = wr_evt && wr_addr_h_q == rpsmc_pkg::ADDR_SCAN
                       && wr_data_h_q[rpsmc_pkg::SCAN_INDEX];
  assign power_down_bit       = cfg_q[rpsmc_pkg::CFG_POWER_DOWN_BIT];
  assign det         = dir_sync_q[1] && !power_down_bit;
  assign scanning    = state_q == rpsmc_pkg::SCAN_DWELL;
  assign det_ok      = det && blank_q == 2'h0;

  // ************************************************************
  // Host registers, written in every power mode
  // ************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      cfg_q   <= rpsmc_pkg::RST_CFG;
      scan_q  <= rpsmc_pkg::RST_SCAN;
      rx_threshold_tx_level_q  <= rpsmc_pkg::RST_RX_THRESHOLD_TX_LEVEL;
      ping_q  <= rpsmc_pkg::RST_PING;
      dwell_q <= rpsmc_pkg::RST_DWELL;
    end else if (wr_evt) begin
      unique case (wr_addr_h_q)
        rpsmc_pkg::ADDR_CFG:   cfg_q   <= wr_data_h_q;
        rpsmc_pkg::ADDR_SCAN:  scan_q  <= wr_data_h_q[7:4];
        rpsmc_pkg::ADDR_RX_THRESHOLD_TX_LEVEL:  rx_threshold_tx_level_q  <= wr_data_h_q;
        rpsmc_pkg::ADDR_PING:  ping_q  <= wr_data_h_q;
        rpsmc_pkg::ADDR_DWELL: dwell_q <= wr_data_h_q;
        default: ;
      endcase
    end
  end

  // ************************************************************
  // Dwell timing
  // ************************************************************
  always_comb begin
    unique case (cfg_q[rpsmc_pkg::CFG_RATE +: 2])
      2'h1:    period = 14'(P_BIT_CYC_38K4);
      2'h2:    period = 14'(P_BIT_CYC_115K);
      default: period = 14'(P_BIT_CYC_9K6);
    endcase
    unique case (scan_q[rpsmc_pkg::SCAN_DW - 4 +: 2])
      rpsmc_pkg::DWELL_SIXTEEN: target = rpsmc_pkg::MULT_SIXTEEN;
      rpsmc_pkg::DWELL_USER:    target = {1'b0, ping_q[rpsmc_pkg::PING_HI +: 4], dwell_q}
                                         + rpsmc_pkg::MULT_ONE;
      default:                  target = rpsmc_pkg::MULT_ONE;
    endcase
  end

  assign manual  = scan_q[rpsmc_pkg::SCAN_DW - 4 +: 2] == rpsmc_pkg::DWELL_MANUAL;
  assign expire  = !manual && bit_tmr_q == (period - 14'h0001)
                   && bit_num_q == (target - rpsmc_pkg::MULT_ONE);
  // Carrier advance needs full-dwell clear; timed modes also need check-all
  assign advance = scanning && (expire || (manual && index_pulse)
                   || (det_ok && !scan_q[rpsmc_pkg::SCAN_FULL - 4]
                       && (manual || scan_q[rpsmc_pkg::SCAN_CHK - 4])));
  assign first_port = find_port(ping_q[rpsmc_pkg::PING_MASK +: 4], 3'h0);
  assign next_port  = find_port(ping_q[rpsmc_pkg::PING_MASK +: 4], {1'b0, mux_q[1:0]} + 3'h1);

  always_ff @(posedge i_mclk) begin
    if (i_reset || !scanning || advance) begin
      bit_tmr_q <= 14'h0000;
      bit_num_q <= 13'h0000;
    end else if (bit_tmr_q == (period - 14'h0001)) begin
      bit_tmr_q <= 14'h0000;
      bit_num_q <= bit_num_q + 13'h0001;
    end else begin
      bit_tmr_q <= bit_tmr_q + 14'h0001;
    end
  end

  // ************************************************************
  // Scan engine and mux control
  // ************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state_q <= rpsmc_pkg::SCAN_IDLE;
      mux_q   <= rpsmc_pkg::RST_MUX;
    end else if (start_pulse) begin
      state_q <= first_port[2] ? rpsmc_pkg::SCAN_DWELL : rpsmc_pkg::SCAN_IDLE;
      if (first_port[2]) begin
        mux_q[1:0] <= first_port[1:0];
      end
    end else if (advance) begin
      state_q <= next_port[2] ? rpsmc_pkg::SCAN_DWELL : rpsmc_pkg::SCAN_IDLE;
      if (next_port[2]) begin
        mux_q[1:0] <= next_port[1:0];
      end
    end else if (wr_evt && wr_addr_h_q == rpsmc_pkg::ADDR_MUX) begin
      mux_q <= wr_data_h_q[2:0];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset || start_pulse) begin
      detect_q <= 4'h0;
    end else if (scanning && det_ok) begin
      detect_q[mux_q[1:0]] <= 1'b1;
    end
  end

  // Mask stale carrier after a port change
  always_ff @(posedge i_mclk) begin
    if (i_reset || start_pulse || advance) begin
      blank_q <= rpsmc_pkg::SETTLE_CYC;
    end else if (blank_q != 2'h0) begin
      blank_q <= blank_q - 2'h1;
    end
  end

  // ************************************************************
  // Power modes and pin outputs
  // ************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_tx_enable                <= 1'b0;
      o_tx_key                   <= 1'b0;
      o_rx_enable                <= 1'b0;
      o_osc_enable               <= 1'b1;
      o_sync_clock_output_enable <= 1'b0;
      o_receive_output           <= 1'b1;
      o_direction                <= 1'b0;
      tx_active_q                <= 1'b0;
    end else begin
      o_tx_enable <= !power_down_bit && !cfg_q[rpsmc_pkg::CFG_STBY];
      o_tx_key    <= !power_down_bit && !cfg_q[rpsmc_pkg::CFG_STBY]
                     && (!transmit_input_pin_sync_q[1] || cfg_q[rpsmc_pkg::CFG_TXON]);
      o_rx_enable <= !power_down_bit;
      o_osc_enable <= !power_down_bit || cfg_q[rpsmc_pkg::CFG_XTAL];
      o_sync_clock_output_enable <= (!power_down_bit || cfg_q[rpsmc_pkg::CFG_XTAL])
                                    && cfg_q[rpsmc_pkg::CFG_OSCBUF +: 2] != 2'h0;
      o_receive_output <= power_down_bit || rxd_sync_q[1];
      o_direction      <= det;
      tx_active_q      <= !transmit_input_pin_sync_q[1] || cfg_q[rpsmc_pkg::CFG_TXON];
    end
  end

  assign o_sync_drive              = cfg_q[rpsmc_pkg::CFG_OSCBUF +: 2];
  assign o_tx_level                = rx_threshold_tx_level_q[rpsmc_pkg::RX_THRESHOLD_TX_LEVEL_PWR +: 4];
  assign o_receive_threshold_field = rx_threshold_tx_level_q[rpsmc_pkg::RX_THRESHOLD_TX_LEVEL_SENS +: 4];
  assign o_data_rate_field         = cfg_q[rpsmc_pkg::CFG_RATE +: 2];
  assign o_mux_port                = mux_q[1:0];
  assign o_mux_open                = mux_q[2];

  // ************************************************************
  // Readback snapshot, frozen during a frame
  // ************************************************************
  always_comb begin
    rd_val[0] = cfg_q;
    rd_val[1] = {5'h00, mux_q};
    rd_val[2] = {scan_q, 4'h0};
    rd_val[3] = rx_threshold_tx_level_q;
    rd_val[4] = ping_q;
    rd_val[5] = dwell_q;
    rd_val[6] = {1'b0, mux_q[1:0], scanning, detect_q};
    rd_val[7] = {5'h00, tx_active_q, o_direction, o_receive_output};
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      for (int i = 0; i < rpsmc_pkg::NUM_REGS; i++) begin
        snap_q[i] <= 8'h00;
      end
    end else if (!cs_sync_q[1]) begin
      for (int i = 0; i < rpsmc_pkg::NUM_REGS; i++) begin
        snap_q[i] <= rd_val[i];
      end
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  property p_cfg_write;
    wr_evt && wr_addr_h_q == rpsmc_pkg::ADDR_CFG |=> cfg_q == $past(wr_data_h_q);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("cfg write lost");

  property p_standby;
    cfg_q[rpsmc_pkg::CFG_STBY] ##1 cfg_q[rpsmc_pkg::CFG_STBY] |-> !o_tx_enable && !o_tx_key;
  endproperty
  a_standby: assert property (p_standby) else $error("tx on in standby");

  property p_power_down_bit;
    power_down_bit ##1 power_down_bit |-> o_receive_output && !o_direction && !o_rx_enable;
  endproperty
  a_power_down_bit: assert property (p_power_down_bit) else $error("rx on in power-down");

  property p_osc;
    (power_down_bit && !cfg_q[rpsmc_pkg::CFG_XTAL]) [*2] |-> !o_osc_enable
                                                 && !o_sync_clock_output_enable;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator kept");

  property p_start;
    start_pulse && first_port[2] |=> scanning && o_mux_port == $past(first_port[1:0])
                                     && detect_q == 4'h0;
  endproperty
  a_start: assert property (p_start) else $error("scan start wrong");

  property p_empty;
    start_pulse && ping_q[3:0] == 4'h0 |=> !scanning ##1 detect_q == 4'h0;
  endproperty
  a_empty: assert property (p_empty) else $error("empty scan ran");

  property p_step;
    advance && next_port[2] |=> scanning && o_mux_port == $past(next_port[1:0])
                                && ping_q[o_mux_port];
  endproperty
  a_step: assert property (p_step) else $error("bad next port");

  property p_done;
    advance && !next_port[2] && !start_pulse |=> !scanning;
  endproperty
  a_done: assert property (p_done) else $error("scan did not end");

  property p_detect;
    scanning && det_ok && !start_pulse |=> detect_q[$past(mux_q[1:0])];
  endproperty
  a_detect: assert property (p_detect) else $error("detection not recorded");

  property p_hold;
    !start_pulse && !scanning |=> detect_q == $past(detect_q);
  endproperty
  a_hold: assert property (p_hold) else $error("results changed");

  property p_txact;
    ##1 1'b1 |-> tx_active_q == $past(!transmit_input_pin_sync_q[1] || cfg_q[rpsmc_pkg::CFG_TXON]);
  endproperty
  a_txact: assert property (p_txact) else $error("tx active wrong");

  property p_manual;
    scanning && manual && !index_pulse && !det_ok && !start_pulse |=> $stable(mux_q[1:0]);
  endproperty
  a_manual: assert property (p_manual) else $error("manual moved");

  c_start: cover property (start_pulse && first_port[2]);
  c_step:  cover property (advance && next_port[2]);
  c_done:  cover property (scanning ##1 !scanning);
  c_early: cover property (scanning && det_ok && advance && !expire);

endmodule

// ===== verification/rpsmc_host_model.sv
// Host model: drives 16-bit serial frames and collects read data
// Assumes the device samples on the rising serial clock edge
`timescale 1ns/1ps
module rpsmc_host_model (
  output logic      o_spi_clk,
  output logic      o_select_n,
  output logic      o_mosi,
  input  wire logic i_miso
);
  initial begin
    o_spi_clk  = 1'b0;
    o_select_n = 1'b1;
    o_mosi     = 1'b0;
  end
  // ****************
  // Frame: flag, address, data
  // ****************
  task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] wd,
                      output logic [7:0] rd);
    logic [15:0] f;
    f = {rw, a, wd};
    rd = 8'h00;
    #2.3 o_select_n = 1'b0;
    #40;
    for (int k = 15; k >= 0; k--) begin
      o_mosi = f[k];
      #3 o_spi_clk = 1'b1;
      if (k < 8) rd = {rd[6:0], i_miso};
      #3 o_spi_clk = 1'b0;
    end
    #3 o_mosi = ~o_mosi;
    #40 o_select_n = 1'b1;
    #120;
  endtask
endmodule

// ===== verification/rpsmc_top_test.sv
// Testbench: registers, power modes, status bits and port scan
// Assumes the host model owns the serial pins; carrier is modelled here
`timescale 1ns/1ps
module rpsmc_top_test;
  logic       i_mclk, i_reset, spi_clk, sel_n, mosi, miso, transmit_input_pin, rx_raw, dir_raw, dir_f;
  logic       rx_out, dir_out, tx_en, tx_key, rx_en, osc_en, sync_en, asc_bad, car_on;
  logic       oe_n, mux_open;
  logic [1:0] mux, lm, sync_drv, rate;
  logic [3:0] seen, tx_lvl, thr;
  logic [7:0] r, v, x, nl;
  int         n_mismatch, total_checks, age, car_port, per;
  int         dur [4];
  logic [7:0] mv [3] = '{8'h46, 8'hC6, 8'hA6};
  logic [5:0] me [3] = '{6'b000001, 6'b001101, 6'b011110};

  rpsmc_top #(.P_BIT_CYC_9K6(20), .P_BIT_CYC_38K4(10), .P_BIT_CYC_115K(5)) u_dut (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_spi_clk(spi_clk), .i_serial_select_n(sel_n),
    .i_serial_in(mosi), .o_serial_out(miso), .o_serial_out_oe_n(oe_n),
    .i_transmit_input_pin(transmit_input_pin), .i_rx_data_raw(rx_raw), .i_direction_raw(dir_raw),
    .o_receive_output(rx_out), .o_direction(dir_out), .o_tx_enable(tx_en),
    .o_tx_key(tx_key), .o_rx_enable(rx_en), .o_osc_enable(osc_en),
    .o_sync_clock_output_enable(sync_en), .o_sync_drive(sync_drv), .o_tx_level(tx_lvl),
    .o_receive_threshold_field(thr), .o_data_rate_field(rate), .o_mux_port(mux),
    .o_mux_open(mux_open));
  rpsmc_host_model u_host (.o_spi_clk(spi_clk), .o_select_n(sel_n), .o_mosi(mosi),
    .i_miso(miso));

  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // Port dwell monitor and carrier on one port mid-dwell
  always @(negedge i_mclk) begin
    if (mux !== lm) begin
      dur[lm] = age + 1;
      age = 0;
      if (mux < lm) asc_bad = 1'b1;
    end else age++;
    lm = mux;
    seen[mux] = 1'b1;
    dir_raw <= dir_f | (car_on && mux == car_port && age >= 20 && age < 30);
  end
  // ****************
  // Tasks
  // ****************
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.xfer(1'b0, a, d, v);
  endtask
  task automatic rd(input logic [6:0] a);
    u_host.xfer(1'b1, a, 8'h00, r);
  endtask
  task automatic rc(input logic [6:0] a, input logic [7:0] exp);
    rd(a);
    cmp(r, exp);
  endtask
  task automatic start(input logic [7:0] s);
    wr(7'h01, 8'h00);
    seen = 4'h0;
    asc_bad = 1'b0;
    wr(7'h02, s);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 80; i++) begin
      rd(7'h06);
      if (r[4] === 1'b0) return;
    end
    n_mismatch++;
    conclude();
  endtask
  initial begin
    #900000;
    n_mismatch++;
    conclude();
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    void'($urandom(30400));
    {transmit_input_pin, rx_raw, dir_f, car_on} = 4'b1100;
    {age, lm, n_mismatch, total_checks, car_port} = '0;
    i_reset = 1'b1;
    repeat (16) @(negedge i_mclk);
    i_reset = 1'b0;
    repeat (8) @(negedge i_mclk);
    rc(7'h00, 8'h84);
    rc(7'h02, 8'h50);
    rc(7'h04, 8'h0F);
    rc(7'h08, 8'h00);
    x = $urandom;
    wr(7'h03, x);
    rc(7'h03, x);
    cmp({thr, tx_lvl}, x);
    wr(7'h01, 8'h05);
    rc(7'h01, 8'h05);
    cmp({oe_n, mux_open, mux, sync_drv, rate}, 8'hD4);
    for (int i = 0; i < 8; i++) begin
      x = $urandom;
      @(negedge i_mclk);
      {transmit_input_pin, rx_raw, dir_f} = x[2:0];
      wr(7'h00, {3'b100, x[3], 4'h6});
      repeat (10) @(negedge i_mclk);
      cmp(tx_key, !x[2] | x[3]);
      cmp({dir_out, rx_out}, {x[0], x[1]});
      rc(7'h07, {5'h0, !x[2] | x[3], x[0], x[1]});
    end
    x = r;
    wr(7'h07, ~x);
    rc(7'h07, x);
    @(negedge i_mclk);
    {transmit_input_pin, rx_raw, dir_f} = 3'b101;
    for (int i = 0; i < 3; i++) begin
      wr(7'h00, mv[i]);
      repeat (10) @(negedge i_mclk);
      cmp({tx_en, rx_en, osc_en, sync_en, dir_out, rx_out}, me[i]);
      rc(7'h00, mv[i]);
    end
    @(negedge i_mclk);
    {rx_raw, dir_f} = 2'b10;
    wr(7'h00, 8'h86);
    for (int c = 1; c < 4; c++) begin
      nl = $urandom_range(15);
      car_port = $urandom_range(3, 1);
      per = (c == 1) ? 5 : (c == 2) ? 80 : 5 * (nl + 1);
      car_on = per >= 40;
      wr(7'h05, nl);
      start({2'b01, c[1:0], 4'h1});
      wait_idle();
      cmp(dur[1] == per || dur[1] == per + 1, 1'b1);
      cmp(seen, 4'hF);
      cmp(asc_bad, 1'b0);
      cmp(r[4:0], car_on ? 5'h1 << car_port : 5'h0);
    end
    car_on = 1'b1;
    car_port = 1;
    start(8'h01);
    rc(7'h02, 8'h00);
    rd(7'h06);
    cmp(r[6:4], 3'b001);
    repeat (100) @(negedge i_mclk);
    cmp(mux, 2'h0);
    wr(7'h02, 8'h02);
    repeat (60) @(negedge i_mclk);
    cmp(mux, 2'h2);
    wr(7'h02, 8'h02);
    wr(7'h02, 8'h02);
    wait_idle();
    cmp(r[4:0], 5'h02);
    repeat (200) @(negedge i_mclk);
    rd(7'h06);
    cmp(r[3:0], 4'h2);
    wr(7'h04, 8'h00);
    start(8'h01);
    rd(7'h06);
    cmp(r[4:0], 5'h00);
    conclude();
  end
endmodule
